// ### hdl/sem_pkg.sv
// Constants, types and register map of the serial EEPROM-style programming host
package sem_pkg;

	// ----------------------------------------------------------------
	// Clock and serial timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ      = 40_000_000;
	localparam int unsigned SCK_HZ      = 4_000_000;
	localparam int unsigned SCK_MAX_HZ  = 8_000_000;
	// Half serial clock period in pclk cycles, also used for select setup, hold and gap
	localparam logic [3:0]  HALF_CNT    = 4'(CLK_HZ / (2 * SCK_HZ));

	// ----------------------------------------------------------------
	// Link opcodes and limits
	// ----------------------------------------------------------------
	localparam logic [7:0]  READ_OPCODE = 8'h03;
	localparam logic [7:0]  WRITE_ENABLE_OPCODE = 8'h06;
	localparam logic [7:0]  WRITE_OPCODE = 8'h02;
	localparam logic [7:0]  DUMMY_BYTE  = 8'h00;
	localparam logic [7:0]  MAX_LEN     = 8'h80;
	localparam logic [7:0]  HDR_BYTES   = 8'h04;
	localparam logic [23:0] FLASH_LO    = 24'h008000;
	localparam logic [23:0] FLASH_HI    = 24'h027FFF;
	localparam logic [23:0] EE_LO       = 24'h004000;
	localparam logic [23:0] EE_HI       = 24'h0047FF;

	// ----------------------------------------------------------------
	// Register offsets, fields and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFF_CTRL    = 8'h00;
	localparam logic [7:0]  OFF_ADDR    = 8'h04;
	localparam logic [7:0]  OFF_LEN     = 8'h08;
	localparam logic [7:0]  OFF_STAT    = 8'h0C;
	localparam logic [7:0]  OFF_DATA    = 8'h10;
	localparam logic [7:0]  OFF_IDX     = 8'h14;
	localparam int unsigned CTRL_START  = 0;
	localparam int unsigned CTRL_CMD    = 1;
	localparam int unsigned STAT_BUSY   = 0;
	localparam int unsigned STAT_DONE   = 1;
	localparam int unsigned STAT_ERR    = 2;
	localparam logic [23:0] ADDR_RST    = 24'h000000;
	localparam logic [7:0]  LEN_RST     = 8'h00;
	localparam logic [6:0]  IDX_RST     = 7'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		CMD_READ  = 2'b00,
		CMD_WREN  = 2'b01,
		CMD_WRITE = 2'b10
	} sem_cmd_t;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_SEL  = 3'b001,
		ST_LOAD = 3'b010,
		ST_BYTE = 3'b011,
		ST_WAIT = 3'b100,
		ST_HOLD = 3'b101,
		ST_GAP  = 3'b110
	} sem_state_t;

	typedef struct packed
	{
		logic sck;
		logic mosi;
		logic cs_n;
	} sem_link_t;

endpackage

// ### hdl/sem_buf.sv
// Byte buffer for write data and read results, registered read port
`timescale 1ns/1ps
module sem_buf
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Write port
	input  wire logic       we,
	input  wire logic [6:0] waddr,
	input  wire logic [7:0] wdata,
	// Read port
	input  wire logic [6:0] raddr,
	output logic      [7:0] rdata
);

	logic [7:0] mem_q [0:127];

	// Storage has no reset, contents are only meaningful once written
	always_ff @(posedge pclk)
	begin
		if (we)
			mem_q[waddr] <= wdata;
	end

	// Read data always comes out of a register, one cycle after the address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata <= 8'h00;
		else
			rdata <= mem_q[raddr];
	end

endmodule

// ### hdl/sem_shift.sv
// Byte shifter that makes the serial clock and moves one byte each way
`timescale 1ns/1ps
module sem_shift
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Byte request
	input  wire logic       start,
	input  wire logic [7:0] tx_byte,
	output logic      [7:0] rx_byte,
	output logic            done,
	// Link side, data in already synchronised
	input  wire logic       miso_s,
	output logic            sck,
	output logic            mosi
);

	logic [3:0] cnt_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q;
	logic       act_q;

	assign rx_byte = sh_q;

	// Idle-low clock, sample on rising edge, change on falling, MSB first [RULE14]
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= 4'h0;
			bit_q <= 3'h0;
			sh_q  <= 8'h00;
			act_q <= 1'b0;
			sck   <= 1'b0;
			mosi  <= 1'b0;
			done  <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start && !act_q)
			begin
				act_q <= 1'b1;
				sh_q  <= tx_byte;
				mosi  <= tx_byte[7];
				bit_q <= 3'h7;
				cnt_q <= sem_pkg::HALF_CNT - 4'h1;
			end
			else if (act_q)
			begin
				if (cnt_q != 4'h0)
					cnt_q <= cnt_q - 4'h1;
				else
				begin
					cnt_q <= sem_pkg::HALF_CNT - 4'h1;
					if (!sck)
					begin
						sck  <= 1'b1;
						sh_q <= {sh_q[6:0], miso_s}; // Sample on rising edge [RULE14]
					end
					else
					begin
						sck <= 1'b0;
						if (bit_q == 3'h0)
						begin
							act_q <= 1'b0;
							done  <= 1'b1;
						end
						else
						begin
							bit_q <= bit_q - 3'h1;
							mosi  <= sh_q[7]; // Next bit after falling edge [RULE14]
						end
					end
				end
			end
		end
	end

endmodule

// ### hdl/sem_host.sv
// Host controller that reads and programs an EEPROM-style serial memory target
//
// Notes on behaviour
// [RULE1] A frame opening with 03h reads memory.
// [RULE2] A lone 06h in its own select period arms writing.
// [RULE3] A frame opening with 02h writes; target programs after select rises.
// [RULE4] Read and write opcodes are followed by three address bytes, MSB first.
// [RULE5] Start addresses lie in program flash or data EEPROM windows.
// [RULE6] Select stays low over opcode, address and all dummy bytes.
// [RULE7] Target answers 00h during header bytes, then memory data.
// [RULE8] One dummy 00h byte is sent per byte read; addresses increment.
// [RULE9] A write is preceded by its own write-enable frame.
// [RULE10] At most 128 data bytes per write frame.
// [RULE11] Target programs the data from the start address when select rises.
// [RULE12] Target answers 00h on every byte of enable and write frames.
// [RULE13] Status register commands are never issued.
// [RULE14] Idle-low clock, sample rising, change falling, MSB first, low select.
// [RULE15] Serial clock stays at or below half the target core clock.
// [RULE16] Serial clock runs at the recommended 4 MHz.
// [RULE17] Target ignores writes without enable and clears enable after programming.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module sem_host
(
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial link
	output logic             sck,
	output logic             mosi,
	output logic             chip_select_n,
	input  wire logic        miso
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Offset is one of the host's registers
	function automatic logic off_mapped(input logic [31:0] a);
		off_mapped = (a[31:8] == 24'h000000) &&
			(a[7:0] == sem_pkg::OFF_CTRL || a[7:0] == sem_pkg::OFF_ADDR ||
			 a[7:0] == sem_pkg::OFF_LEN  || a[7:0] == sem_pkg::OFF_STAT ||
			 a[7:0] == sem_pkg::OFF_DATA || a[7:0] == sem_pkg::OFF_IDX);
	endfunction

	// Start address inside program flash or data EEPROM
	function automatic logic addr_ok(input logic [23:0] a);
		addr_ok = (a >= sem_pkg::FLASH_LO && a <= sem_pkg::FLASH_HI) ||
			(a >= sem_pkg::EE_LO && a <= sem_pkg::EE_HI); // [RULE5]
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	sem_pkg::sem_state_t state_q;
	sem_pkg::sem_cmd_t   cmd_q;
	sem_pkg::sem_link_t  link;
	logic [23:0]         addr_q;
	logic [7:0]          len_q;
	logic [6:0]          idx_q;
	logic                done_q;
	logic                err_q;
	logic [7:0]          byte_q;
	logic                frame_wren_q;
	logic [3:0]          wait_q;
	logic                miso_m_q;
	logic                miso_s_q;
	logic                pready_q;
	logic                pslverr_q;
	logic [31:0]         prdata_q;
	logic                busy;
	logic                acc;
	logic                commit;
	logic                wr_en;
	logic                rd_en;
	logic [7:0]          off;
	logic                start_req;
	logic                start_ok;
	sem_pkg::sem_cmd_t   new_cmd;
	logic [7:0]          last_byte;
	logic [6:0]          data_idx;
	logic [7:0]          tx_byte;
	logic [7:0]          rx_byte;
	logic                sh_start;
	logic                sh_done;
	logic                buf_we;
	logic [6:0]          buf_waddr;
	logic [7:0]          buf_wdata;
	logic [6:0]          buf_raddr;
	logic [7:0]          buf_rdata;
	logic                set_done;

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------

	// Every access takes one wait state so prdata and pslverr come from flops
	assign acc     = psel && penable;
	assign commit  = acc && pready_q;
	assign off     = paddr[7:0];
	assign wr_en   = commit && pwrite && !pslverr_q;
	assign rd_en   = commit && !pwrite && !pslverr_q;
	assign pready  = pready_q;
	assign pslverr = pready_q && pslverr_q;
	assign prdata  = prdata_q;
	assign busy    = (state_q != sem_pkg::ST_IDLE);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready_q <= 1'b0;
		else
			pready_q <= acc && !pready_q;
	end

	// Refuse unmapped offsets, and anything but status while a frame runs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr_q <= 1'b0;
		else if (acc && !pready_q)
			pslverr_q <= !off_mapped(paddr) || (busy && off != sem_pkg::OFF_STAT);
	end

	// Read data captured in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h00000000;
		else if (acc && !pready_q && !pwrite)
		begin
			unique case (off)
				sem_pkg::OFF_CTRL: prdata_q <= {29'h00000000, cmd_q, 1'b0};
				sem_pkg::OFF_ADDR: prdata_q <= {8'h00, addr_q};
				sem_pkg::OFF_LEN:  prdata_q <= {24'h000000, len_q};
				sem_pkg::OFF_STAT: prdata_q <= {29'h00000000, err_q, done_q, busy};
				sem_pkg::OFF_DATA: prdata_q <= {24'h000000, buf_rdata};
				sem_pkg::OFF_IDX:  prdata_q <= {25'h0000000, idx_q};
				default:           prdata_q <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	assign start_req = wr_en && off == sem_pkg::OFF_CTRL && pwdata[sem_pkg::CTRL_START];
	assign new_cmd   = sem_pkg::sem_cmd_t'(pwdata[sem_pkg::CTRL_CMD +: 2]);

	// Only read, enable and write are accepted; status commands do not exist [RULE13]
	always_comb
	begin
		unique case (new_cmd)
			sem_pkg::CMD_WREN:  start_ok = 1'b1;
			sem_pkg::CMD_READ,
			sem_pkg::CMD_WRITE: start_ok = len_q != 8'h00 && len_q <= sem_pkg::MAX_LEN // [RULE10]
				&& addr_ok(addr_q); // [RULE5]
			default:            start_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_q <= sem_pkg::ADDR_RST;
			len_q  <= sem_pkg::LEN_RST;
		end
		else if (wr_en && off == sem_pkg::OFF_ADDR)
			addr_q <= pwdata[23:0];
		else if (wr_en && off == sem_pkg::OFF_LEN)
			len_q <= pwdata[7:0];
	end

	// Buffer index, moves on after every accepted data access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			idx_q <= sem_pkg::IDX_RST;
		else if (wr_en && off == sem_pkg::OFF_IDX)
			idx_q <= pwdata[6:0];
		else if ((wr_en || rd_en) && off == sem_pkg::OFF_DATA)
			idx_q <= idx_q + 7'h01;
	end

	// Sticky flags, cleared by writing one; a same-cycle set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_q <= 1'b0;
			err_q  <= 1'b0;
		end
		else
		begin
			if (set_done)
				done_q <= 1'b1;
			else if (wr_en && off == sem_pkg::OFF_STAT && pwdata[sem_pkg::STAT_DONE])
				done_q <= 1'b0;
			if (start_req && !start_ok)
				err_q <= 1'b1;
			else if (wr_en && off == sem_pkg::OFF_STAT && pwdata[sem_pkg::STAT_ERR])
				err_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------

	// Enable frame is opcode only, others carry header plus data [RULE4]
	assign last_byte = frame_wren_q ? 8'h00 : sem_pkg::HDR_BYTES - 8'h01 + len_q;
	assign data_idx  = 7'(byte_q - sem_pkg::HDR_BYTES);
	assign sh_start  = (state_q == sem_pkg::ST_BYTE);
	assign set_done  = (state_q == sem_pkg::ST_GAP) && wait_q == 4'h0 && !(cmd_q == sem_pkg::CMD_WRITE
		&& frame_wren_q);

	// Byte to send for the current position
	always_comb
	begin
		tx_byte = sem_pkg::DUMMY_BYTE; // One dummy byte per byte read [RULE8]
		if (byte_q == 8'h00)
		begin
			if (frame_wren_q)
				tx_byte = sem_pkg::WRITE_ENABLE_OPCODE; // [RULE2]
			else if (cmd_q == sem_pkg::CMD_READ)
				tx_byte = sem_pkg::READ_OPCODE; // [RULE1]
			else
				tx_byte = sem_pkg::WRITE_OPCODE; // [RULE3]
		end
		else if (byte_q == 8'h01)
			tx_byte = addr_q[23:16]; // [RULE4]
		else if (byte_q == 8'h02)
			tx_byte = addr_q[15:8];
		else if (byte_q == 8'h03)
			tx_byte = addr_q[7:0];
		else if (cmd_q == sem_pkg::CMD_WRITE)
			tx_byte = buf_rdata;
	end

	// Main state, select and counters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q       <= sem_pkg::ST_IDLE;
			cmd_q         <= sem_pkg::CMD_READ;
			frame_wren_q  <= 1'b0;
			byte_q        <= 8'h00;
			wait_q        <= 4'h0;
			chip_select_n <= 1'b1;
		end
		else
		begin
			unique case (state_q)
				sem_pkg::ST_IDLE:
				begin
					if (start_req && start_ok)
					begin
						cmd_q         <= new_cmd;
						// Write is sent only after a separate enable frame [RULE9]
						frame_wren_q  <= (new_cmd != sem_pkg::CMD_READ);
						byte_q        <= 8'h00;
						wait_q        <= sem_pkg::HALF_CNT;
						chip_select_n <= 1'b0; // Active-low select [RULE14]
						state_q       <= sem_pkg::ST_SEL;
					end
				end
				sem_pkg::ST_SEL:
				begin
					if (wait_q != 4'h0)
						wait_q <= wait_q - 4'h1;
					else
						state_q <= sem_pkg::ST_LOAD;
				end
				sem_pkg::ST_LOAD:
					state_q <= sem_pkg::ST_BYTE; // Buffer read settles here
				sem_pkg::ST_BYTE:
					state_q <= sem_pkg::ST_WAIT;
				sem_pkg::ST_WAIT:
				begin
					if (sh_done)
					begin
						if (byte_q == last_byte)
						begin
							wait_q  <= sem_pkg::HALF_CNT;
							state_q <= sem_pkg::ST_HOLD;
						end
						else
						begin
							byte_q  <= byte_q + 8'h01; // Select stays low between bytes [RULE6]
							state_q <= sem_pkg::ST_LOAD;
						end
					end
				end
				sem_pkg::ST_HOLD:
				begin
					if (wait_q != 4'h0)
						wait_q <= wait_q - 4'h1;
					else
					begin
						chip_select_n <= 1'b1; // Rising select starts programming [RULE11]
						wait_q        <= sem_pkg::HALF_CNT;
						state_q       <= sem_pkg::ST_GAP;
					end
				end
				sem_pkg::ST_GAP:
				begin
					if (wait_q != 4'h0)
						wait_q <= wait_q - 4'h1;
					else if (cmd_q == sem_pkg::CMD_WRITE && frame_wren_q)
					begin
						// Enable frame closed, open the write frame [RULE9]
						frame_wren_q  <= 1'b0;
						byte_q        <= 8'h00;
						wait_q        <= sem_pkg::HALF_CNT;
						chip_select_n <= 1'b0;
						state_q       <= sem_pkg::ST_SEL;
					end
					else
						state_q <= sem_pkg::ST_IDLE;
				end
				default:
					state_q <= sem_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Buffer and byte shifter
	// ----------------------------------------------------------------

	// Header answers are 00h and carry nothing, only data bytes are kept [RULE7]
	assign buf_we    = busy ? (state_q == sem_pkg::ST_WAIT && sh_done && cmd_q == sem_pkg::CMD_READ
		&& byte_q >= sem_pkg::HDR_BYTES) : (wr_en && off == sem_pkg::OFF_DATA); // [RULE8]
	assign buf_waddr = busy ? data_idx : idx_q;
	assign buf_wdata = busy ? rx_byte : pwdata[7:0];
	assign buf_raddr = busy ? data_idx : idx_q;

	sem_buf u_buf
	(
		.pclk    (pclk),
		.presetn (presetn),
		.we      (buf_we),
		.waddr   (buf_waddr),
		.wdata   (buf_wdata),
		.raddr   (buf_raddr),
		.rdata   (buf_rdata)
	);

	// Data in comes from a pin, two flops before any logic sees it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			miso_m_q <= 1'b0;
			miso_s_q <= 1'b0;
		end
		else
		begin
			miso_m_q <= miso;
			miso_s_q <= miso_m_q;
		end
	end

	// Serial clock at 4 MHz, well under the 8 MHz limit [RULE15] [RULE16]
	sem_shift u_shift
	(
		.pclk    (pclk),
		.presetn (presetn),
		.start   (sh_start),
		.tx_byte (tx_byte),
		.rx_byte (rx_byte),
		.done    (sh_done),
		.miso_s  (miso_s_q),
		.sck     (link.sck),
		.mosi    (link.mosi)
	);

	assign link.cs_n = chip_select_n;
	assign sck       = link.sck;
	assign mosi      = link.mosi;

endmodule

// ### dv/sem_host_chk.sv
// Concurrent checks on the APB and serial link ports of the programming host
`timescale 1ns/1ps
module sem_host_chk
(
	// APB side
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Serial link
	input wire logic        sck,
	input wire logic        mosi,
	input wire logic        chip_select_n,
	input wire logic        miso
);
	// ----------------------------------------------------------------
	// Timing relations
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// First access cycle waits, second one answers
	sequence s_access_wait;
		psel && penable && !pready;
	endsequence
	// One high half of the serial clock, five pclk long
	sequence s_high_half;
		sck[*5] ##1 !sck;
	endsequence

	a_apb_wait_state: assert property ($rose(penable) && psel |-> s_access_wait ##1 pready)
		else $error("pready not given in the second access cycle");
	a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside a completing access");
	a_sck_idle_low: assert property (chip_select_n |-> !sck)
		else $error("serial clock high outside a frame");
	a_select_held: assert property (sck |-> !chip_select_n)
		else $error("select not held low while clocking");
	a_mosi_steady: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("mosi changed while clock high");
	a_sck_high_half: assert property ($rose(sck) |-> s_high_half)
		else $error("clock high half not five cycles");
	a_sck_low_half: assert property ($fell(sck) |-> !sck[*5])
		else $error("clock low half shorter than five cycles");
	a_select_setup: assert property ($fell(chip_select_n) |-> !sck[*5])
		else $error("clock rose too soon after select fell");
	a_frame_gap: assert property ($rose(chip_select_n) |-> chip_select_n[*5])
		else $error("select gap between frames too short");
endmodule

bind sem_host sem_host_chk chk_u
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sck(sck), .mosi(mosi), .chip_select_n(chip_select_n), .miso(miso)
);

// ### dv/sem_eep_model.sv
// Behavioural EEPROM-style serial memory target that answers the host on the link
`timescale 1ns/1ps
module sem_eep_model
(
	// Serial link
	input  wire logic sck,
	input  wire logic mosi,
	input  wire logic chip_select_n,
	output logic      miso
);
	logic [7:0]  mem [int];
	logic [7:0]  wbuf [$];
	logic [7:0]  sh = 8'h00;
	logic [7:0]  tx = 8'h00;
	logic [7:0]  op = 8'h00;
	logic [23:0] ptr = 24'h000000;
	logic        wel = 1'b0;
	int          bitc = 0;
	int          bytec = 0;
	int          frames = 0;
	int          viol = 0;

	// Unwritten cells read back as a pattern tied to the address
	function automatic logic [7:0] rd(input logic [23:0] ad);
		return mem.exists(ad) ? mem[ad] : ~ad[7:0];
	endfunction

	initial
		miso = 1'b0;

	// Frame start: header bytes answer 00h
	always @(negedge chip_select_n)
	begin
		bitc = 0;
		bytec = 0;
		tx = 8'h00;
		miso = tx[7];
		wbuf.delete();
	end

	// Sample on the rising edge, MSB first, and act on each whole byte
	always @(posedge sck)
	if (!chip_select_n)
	begin
		sh = {sh[6:0], mosi};
		bitc = bitc + 1;
		if (bitc == 8)
		begin
			bitc = 0;
			tx = 8'h00;
			if (bytec == 0)
				op = sh;
			else if (bytec < 4)
				ptr = {ptr[15:0], sh};
			else if (op == 8'h02)
				wbuf.push_back(sh);
			else if (op == 8'h03)
				ptr = ptr + 24'h000001;
			if (bytec == 0 && op != 8'h03 && op != 8'h06 && op != 8'h02)
				viol++;
			if (op == 8'h03 && bytec >= 3)
				tx = rd(ptr);
			bytec = bytec + 1;
		end
	end

	// Change data on the falling edge
	always @(negedge sck)
	if (!chip_select_n)
		miso = tx[7 - bitc];

	// Select rises: program a write, arm on a lone enable; released line inverts once and then holds
	always @(posedge chip_select_n)
	begin
		miso = ~miso;
		if (bytec > 0)
		begin
			frames++;
			if (bitc != 0 || (op == 8'h06 && bytec != 1))
				viol++;
			if (op == 8'h02)
			begin
				if (!wel || bytec < 5 || wbuf.size() > 128)
					viol++;
				else if ((ptr >= sem_pkg::FLASH_LO && ptr <= sem_pkg::FLASH_HI) ||
					(ptr >= sem_pkg::EE_LO && ptr <= sem_pkg::EE_HI))
					foreach (wbuf[k])
						mem[ptr + k] = wbuf[k];
				wel = 1'b0;
			end
			if (op == 8'h06)
				wel = 1'b1;
		end
		bytec = 0;
	end
endmodule

// ### dv/test_sem_host.sv
// Self-checking bench for the serial programming host with a memory target model
`timescale 1ns/1ps
module test_sem_host;
	logic        pclk = 1'b0;
	logic        presetn;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sck;
	logic        mosi;
	logic        chip_select_n;
	logic        miso;
	logic [31:0] rv;
	logic [31:0] re;
	logic [7:0]  wd [128];
	logic [23:0] a;
	int          n;
	int          f0;
	int          error_cnt = 0;
	int          cmp_count = 0;
	logic [7:0]  offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
	logic [1:0]  bc [7] = '{2'h3, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0};
	logic [23:0] ba [7] = '{24'h008000, 24'h008000, 24'h008000, 24'h004800, 24'h007FFF, 24'h028000, 24'h003FFF};
	logic [7:0]  bl [7] = '{8'h01, 8'h00, 8'h81, 8'h01, 8'h01, 8'h01, 8'h01};

	// 40 MHz clock
	always #12.5 pclk = ~pclk;

	sem_host dut_u
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sck(sck), .mosi(mosi), .chip_select_n(chip_select_n), .miso(miso)
	);
	sem_eep_model eep_u
	(
		.sck(sck), .mosi(mosi), .chip_select_n(chip_select_n), .miso(miso)
	);

	// ----------------------------------------------------------------
	// Checking, closing and bus tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask

	// Expected status word with busy clear and the given sticky flags
	function automatic logic [31:0] stat_exp(input logic err, input logic done);
		return {29'h0, err, done, 1'b0};
	endfunction

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One APB transfer; an idle cycle after it keeps strobes from being driven twice per step
	task automatic apb(input logic is_wr, input logic [7:0] off, input logic [31:0] d, input logic [23:0] hi);
		int t;
		psel <= 1'b1;
		pwrite <= is_wr;
		paddr <= {hi, off};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do
		begin
			@(posedge pclk);
			t++;
		end
		while (pready !== 1'b1 && t < 20);
		if (t >= 20)
		begin
			error_cnt++;
			conclude();
		end
		rv = prdata;
		re = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		apb(1'b1, off, d, 24'h0);
	endtask

	task automatic rd(input logic [7:0] off);
		apb(1'b0, off, 32'h0, 24'h0);
	endtask

	task automatic go(input logic [1:0] c, input logic [23:0] ad, input logic [7:0] ln);
		wr(sem_pkg::OFF_ADDR, {8'h0, ad});
		wr(sem_pkg::OFF_LEN, {24'h0, ln});
		wr(sem_pkg::OFF_CTRL, {29'h0, c, 1'b1});
	endtask

	// Status polling is allowed while busy; bounded so a hang ends the run
	task automatic wait_idle();
		int t;
		t = 0;
		do
		begin
			rd(sem_pkg::OFF_STAT);
			t++;
		end
		// A 132-byte frame runs about 11000 cycles, some 2800 polls of four cycles
		while (rv[sem_pkg::STAT_BUSY] !== 1'b0 && t < 4000);
		if (t >= 4000)
		begin
			error_cnt++;
			conclude();
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		// Driven at time zero so the asynchronous reset sees a real falling edge
		presetn <= 1'b0;
		void'($urandom(71));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (offs[i])
		begin
			rd(offs[i]);
			chk(rv, 32'h0);
		end
		apb(1'b0, 8'h18, 32'h0, 24'h0);
		chk(re, 32'h1);
		apb(1'b1, sem_pkg::OFF_ADDR, 32'h0, 24'h000001);
		chk(re, 32'h1);
		// Starts the host must refuse: nothing may reach the link
		foreach (bc[i])
		begin
			f0 = eep_u.frames;
			go(bc[i], ba[i], bl[i]);
			rd(sem_pkg::OFF_STAT);
			chk(rv, stat_exp(1'b1, 1'b0));
			chk(32'(eep_u.frames - f0), 32'h0);
			wr(sem_pkg::OFF_STAT, 32'h6);
		end
		f0 = eep_u.frames;
		go(2'h1, 24'h008000, 8'h01);
		wait_idle();
		chk(rv, stat_exp(1'b0, 1'b1));
		chk({31'h0, eep_u.wel}, 32'h1);
		chk(32'(eep_u.frames - f0), 32'h1);
		wr(sem_pkg::OFF_STAT, 32'h6);
		// Full-length EEPROM write first, then random flash writes; each read back
		for (int k = 0; k < 3; k++)
		begin
			n = (k == 0) ? 128 : 1 + int'($urandom_range(126));
			a = (k == 0) ? 24'h004000 : 24'h008000 + 24'($urandom_range(32'h1F000));
			wr(sem_pkg::OFF_IDX, 32'h0);
			for (int i = 0; i < n; i++)
			begin
				wd[i] = 8'($urandom);
				wr(sem_pkg::OFF_DATA, {24'h0, wd[i]});
			end
			f0 = eep_u.frames;
			go(2'h2, a, 8'(n));
			wr(sem_pkg::OFF_DATA, 32'h0);
			chk(re, 32'h1);
			wait_idle();
			chk(rv, stat_exp(1'b0, 1'b1));
			chk(32'(eep_u.frames - f0), 32'h2);
			for (int i = 0; i < n; i++)
				chk({24'h0, eep_u.mem[a + i]}, {24'h0, wd[i]});
			wr(sem_pkg::OFF_STAT, 32'h6);
			go(2'h0, a, 8'(n));
			wait_idle();
			chk(rv, stat_exp(1'b0, 1'b1));
			wr(sem_pkg::OFF_IDX, 32'h0);
			for (int i = 0; i < n; i++)
			begin
				rd(sem_pkg::OFF_DATA);
				chk(rv, {24'h0, wd[i]});
			end
			wr(sem_pkg::OFF_STAT, 32'h6);
		end
		chk(32'(eep_u.viol), 32'h0);
		conclude();
	end
endmodule
